// ==== src/cpu_port_defines.svh ====
`ifndef CPU_PORT_DEFINES_SVH
`define CPU_PORT_DEFINES_SVH

`define CLK_PERIOD_NS      40
`define RESET_HOLD_NS      100
`define RESET_HOLD_CYC     ((`RESET_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ADDR_W             8
`define DATA_W             16
`define LOW_MSB            7
`define UPPER_LSB          8
`define MEM_DEPTH          256
`define STYLE_DATA_STROBE  1'b0
`define STYLE_RD_WR        1'b1
`define RST_BYTE           8'h00
`define RST_WORD           16'h0000

`endif

// ==== src/cpu_port_device.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "cpu_port_defines.svh"
// Overview of operation
// - mode pin high multiplexed, low non-multiplexed
// - non-multiplexed address from dedicated address lines
// - low bus carries data, address when multiplexed
// - multiplexed data-strobe style: strobe is active-high data strobe
// - non-multiplexed strobe is active-low data strobe
// - read/write style: strobe is read, drive bus
// - data-strobe styles: direction pin picks read/write
// - read/write style: direction pin is write strobe
// - data strobes ignored unless chip select low
// - latch strobe only in multiplexed, else grounded
// - reset clears state, floats all outputs
// - host holds reset low at least 100ns
// - frame select picks wide or auto-polarity format
// - upper data lines carry most significant byte
// - ack low at completion, high, then released
module cpu_port_device
   import cpu_port_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              rst_n,
   cpu_port_if.device             bus,
   input  wire logic              rd_wr_style,
   output logic                   wide_frame_mode,
   output logic                   auto_polarity_mode,
   output logic                   serial_out_hiz,
   output logic                   mem_wr_pulse,
   output logic [7:0]             mem_wr_addr,
   output logic [15:0]            mem_wr_data
);
   logic [15:0] mem [0:`MEM_DEPTH-1];

   dev_state_e  state_r, state_nxt;
   logic [7:0]  addr_r, addr_nxt;
   logic [15:0] rdata_r, rdata_nxt;
   logic [15:0] wdata_r, wdata_nxt;
   logic        read_r, read_nxt;
   logic        ale_r, ale_nxt;
   logic        wr_r, wr_nxt;
   logic        wide_r, wide_nxt;
   logic        auto_r, auto_nxt;
   logic        hiz_r, hiz_nxt;
   logic        mem_we;
   logic        ale_fall;
   logic        take;
   access_s     acc;

   // host word as carried by the two data bytes
   function automatic logic [15:0] bus_word(input logic [7:0] hi,
                                            input logic [7:0] lo);
      return {hi, lo};
   endfunction

   assign acc = decode_access(bus.bus_mux_select,
                              rd_wr_style,
                              bus.cs_n,
                              bus.strobe_or_read_n,
                              bus.rw_or_write_n);

   // one access at a time: strobes are only taken from idle
   assign take = (state_r == DEV_IDLE) && acc.active;
   // latch strobe is only looked at in multiplexed operation
   assign ale_fall = bus.bus_mux_select && ale_r
                     && !bus.addr_latch_strobe;

   // access sequence
   always_comb begin
      state_nxt = state_r;
      read_nxt  = read_r;
      rdata_nxt = rdata_r;
      mem_we    = 1'b0;
      case (state_r)
         DEV_IDLE: begin
            if (take) begin
               read_nxt  = acc.is_read;
               state_nxt = DEV_ACCESS;
            end
         end
         DEV_ACCESS: begin
            // read word registered so the bus is fed from a flop
            if (read_r) begin
               rdata_nxt = mem[addr_r];
            end else begin
               // write data sampled one cycle after the strobe is seen
               mem_we = 1'b1;
            end
            state_nxt = DEV_ACK;
         end
         DEV_ACK: begin
            // ack stays low until the host lets the strobe go
            if (!acc.active) begin
               state_nxt = DEV_RELEASE;
            end
         end
         DEV_RELEASE: state_nxt = DEV_IDLE;
         default:     state_nxt = DEV_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= DEV_IDLE;
         read_r  <= 1'b0;
         rdata_r <= `RST_WORD;
      end else begin
         state_r <= state_nxt;
         read_r  <= read_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // address: latched off the low bus, or sampled from the address lines
   // the two sources never meet: one needs mux mode, the other not
   always_comb begin
      addr_nxt = addr_r;
      ale_nxt  = bus.addr_latch_strobe;
      if (ale_fall) begin
         addr_nxt = bus.muxed_low_bus;
      end else if (take && !bus.bus_mux_select) begin
         addr_nxt = bus.dedicated_addr_lines;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         addr_r <= `RST_BYTE;
         ale_r  <= 1'b0;
      end else begin
         addr_r <= addr_nxt;
         ale_r  <= ale_nxt;
      end
   end

   // write notice: a one-cycle pulse with the word just stored
   always_comb begin
      wdata_nxt = wdata_r;
      wr_nxt    = mem_we;
      if (mem_we) begin
         wdata_nxt = bus_word(bus.upper_data_byte,
                              bus.muxed_low_bus);
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wdata_r <= `RST_WORD;
         wr_r    <= 1'b0;
      end else begin
         wdata_r <= wdata_nxt;
         wr_r    <= wr_nxt;
      end
   end

   // frame format follows its pin; serial outputs float only in reset
   // polarity mode has its own flop so the output is registered too
   always_comb begin
      wide_nxt = bus.wide_frame_select;
      auto_nxt = !bus.wide_frame_select;
      hiz_nxt  = 1'b0;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wide_r <= 1'b0;
         auto_r <= 1'b1;
         hiz_r  <= 1'b1;
      end else begin
         wide_r <= wide_nxt;
         auto_r <= auto_nxt;
         hiz_r  <= hiz_nxt;
      end
   end

   // array is not cleared by reset; only control state is
   always_ff @(posedge clk_sys) begin
      if (mem_we) begin
         mem[addr_r] <= bus_word(bus.upper_data_byte, bus.muxed_low_bus);
      end
   end

   assign wide_frame_mode    = wide_r;
   assign auto_polarity_mode = auto_r;
   assign serial_out_hiz     = hiz_r;
   assign mem_wr_pulse       = wr_r;
   assign mem_wr_addr        = addr_r;
   assign mem_wr_data        = wdata_r;

   // bus driven only while the read strobe is still held
   // so a host that drops the strobe early never fights the device
   always_comb begin
      bus.low_dev_oe    = (state_r == DEV_ACK) && read_r
                          && acc.active;
      bus.upper_dev_oe  = bus.low_dev_oe;
      bus.low_dev_out   = rdata_r[`LOW_MSB:0];
      bus.upper_dev_out = rdata_r[`DATA_W-1:`UPPER_LSB];
   end

   // driving high before release lets a weak pull-up suffice
   always_comb begin
      bus.ack_dev_oe  = (state_r == DEV_ACK) ||
                        (state_r == DEV_RELEASE);
      bus.ack_dev_out = (state_r != DEV_ACK);
   end
endmodule
`default_nettype wire

// ==== src/cpu_port_host.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "cpu_port_defines.svh"
module cpu_port_host
   import cpu_port_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              rst_n,
   cpu_port_if.host               bus,
   input  wire logic              mux_mode,
   input  wire logic              rd_wr_style,
   input  wire logic              wide_frame_cfg,
   input  wire logic              reset_req,
   input  wire logic              req_valid,
   input  wire logic              req_write,
   input  wire logic [7:0]        req_addr,
   input  wire logic [15:0]       req_wdata,
   output logic                   req_ready,
   output logic                   resp_valid,
   output logic [15:0]            resp_rdata
);
   host_state_e state_r, state_nxt;
   logic [7:0]  addr_r, addr_nxt;
   logic [15:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
   logic        write_r, write_nxt, resp_r, resp_nxt;
   logic [2:0]  cnt_r, cnt_nxt;
   logic        strobing, rdwr;

   assign rdwr = mux_mode && (rd_wr_style == `STYLE_RD_WR);
   assign strobing = (state_r == HOST_STROBE);
   assign req_ready = (state_r == HOST_IDLE) && !reset_req;
   assign resp_valid = resp_r;
   assign resp_rdata = rdata_r;

   always_comb begin
      state_nxt = state_r;
      addr_nxt  = addr_r;
      wdata_nxt = wdata_r;
      write_nxt = write_r;
      rdata_nxt = rdata_r;
      resp_nxt  = 1'b0;
      cnt_nxt   = cnt_r;
      case (state_r)
         HOST_IDLE: begin
            if (reset_req) begin
               cnt_nxt   = 3'(`RESET_HOLD_CYC);
               state_nxt = HOST_RESET;
            end else if (req_valid) begin
               addr_nxt  = req_addr;
               wdata_nxt = req_wdata;
               write_nxt = req_write;
               state_nxt = mux_mode ? HOST_ADDR : HOST_STROBE;
            end
         end
         HOST_ADDR:   state_nxt = HOST_LATCH;
         HOST_LATCH:  state_nxt = HOST_STROBE;
         HOST_STROBE: begin
            if (!bus.transfer_ack_n) begin
               rdata_nxt = {bus.upper_data_byte, bus.muxed_low_bus};
               resp_nxt  = 1'b1;
               state_nxt = HOST_WAIT;
            end
         end
         HOST_WAIT: begin
            if (bus.transfer_ack_n) begin
               state_nxt = HOST_IDLE;
            end
         end
         HOST_RESET: begin
            cnt_nxt = cnt_r - 3'd1;
            if (cnt_r == 3'd1) begin
               state_nxt = HOST_IDLE;
            end
         end
         default: state_nxt = HOST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= HOST_IDLE;
         addr_r  <= `RST_BYTE;
         wdata_r <= `RST_WORD;
         rdata_r <= `RST_WORD;
         write_r <= 1'b0;
         resp_r  <= 1'b0;
         cnt_r   <= 3'd0;
      end else begin
         state_r <= state_nxt;
         addr_r  <= addr_nxt;
         wdata_r <= wdata_nxt;
         rdata_r <= rdata_nxt;
         write_r <= write_nxt;
         resp_r  <= resp_nxt;
         cnt_r   <= cnt_nxt;
      end
   end

   // pin levels, decoded from the state register, the request registers and the mode inputs
   always_comb begin
      bus.bus_mux_select    = mux_mode;
      bus.wide_frame_select = wide_frame_cfg;
      bus.device_reset_n    = (state_r != HOST_RESET);
      bus.cs_n              = !strobing;
      // ale held low outside multiplexed operation
      bus.addr_latch_strobe = (state_r == HOST_ADDR);
      bus.dedicated_addr_lines = mux_mode ? `RST_BYTE : addr_r;
      if (rdwr) begin
         bus.strobe_or_read_n = !(strobing && !write_r);
         bus.rw_or_write_n    = !(strobing && write_r);
      end else begin
         bus.strobe_or_read_n = mux_mode ? strobing : !strobing;
         bus.rw_or_write_n    = !write_r;
      end
      bus.low_host_oe = (state_r == HOST_ADDR) || (state_r == HOST_LATCH)
                        || (strobing && write_r);
      bus.low_host_out = strobing ? wdata_r[`LOW_MSB:0] : addr_r;
      bus.upper_host_oe  = strobing && write_r;
      bus.upper_host_out = wdata_r[`DATA_W-1:`UPPER_LSB];
   end
endmodule
`default_nettype wire

// ==== src/cpu_port_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface cpu_port_if;
   logic       bus_mux_select;
   logic       wide_frame_select;
   logic       device_reset_n;
   logic       cs_n;
   logic       strobe_or_read_n;
   logic       rw_or_write_n;
   logic       addr_latch_strobe;
   logic [7:0] dedicated_addr_lines;
   logic [7:0] low_host_out;
   logic       low_host_oe;
   logic [7:0] low_dev_out;
   logic       low_dev_oe;
   logic [7:0] upper_host_out;
   logic       upper_host_oe;
   logic [7:0] upper_dev_out;
   logic       upper_dev_oe;
   logic       ack_dev_out;
   logic       ack_dev_oe;
   logic [7:0] muxed_low_bus;
   logic [7:0] upper_data_byte;
   logic       transfer_ack_n;

   // undriven data reads as zero, the ack line has a pull-up
   assign muxed_low_bus = low_dev_oe ? low_dev_out :
                          (low_host_oe ? low_host_out : 8'h00);
   assign upper_data_byte = upper_dev_oe ? upper_dev_out :
                            (upper_host_oe ? upper_host_out : 8'h00);
   assign transfer_ack_n = ack_dev_oe ? ack_dev_out : 1'b1;

   modport device (
      input  bus_mux_select, wide_frame_select, cs_n, strobe_or_read_n,
             rw_or_write_n, addr_latch_strobe, dedicated_addr_lines,
             muxed_low_bus, upper_data_byte,
      output low_dev_out, low_dev_oe, upper_dev_out, upper_dev_oe,
             ack_dev_out, ack_dev_oe
   );

   modport host (
      input  muxed_low_bus, upper_data_byte, transfer_ack_n,
      output bus_mux_select, wide_frame_select, device_reset_n, cs_n,
             strobe_or_read_n, rw_or_write_n, addr_latch_strobe,
             dedicated_addr_lines, low_host_out, low_host_oe,
             upper_host_out, upper_host_oe
   );
endinterface
`default_nettype wire

// ==== src/cpu_port_pkg.sv ====
`default_nettype none
package cpu_port_pkg;

   typedef enum logic [1:0] {
      DEV_IDLE    = 2'b00,
      DEV_ACCESS  = 2'b01,
      DEV_ACK     = 2'b11,
      DEV_RELEASE = 2'b10
   } dev_state_e;

   typedef enum logic [2:0] {
      HOST_IDLE   = 3'b000,
      HOST_ADDR   = 3'b001,
      HOST_LATCH  = 3'b011,
      HOST_STROBE = 3'b010,
      HOST_WAIT   = 3'b110,
      HOST_RESET  = 3'b100
   } host_state_e;

   typedef struct packed {
      logic active;
      logic is_read;
   } access_s;

   // decode of the strobe pair for the current mode and style
   function automatic access_s decode_access(
      input logic mux_mode,
      input logic rd_wr_style,
      input logic cs_n,
      input logic strobe_or_read_n,
      input logic rw_or_write_n);
      access_s a;
      a.active  = 1'b0;
      a.is_read = 1'b0;
      if (!cs_n) begin
         if (mux_mode && rd_wr_style) begin
            a.active  = !strobe_or_read_n || !rw_or_write_n;
            a.is_read = !strobe_or_read_n;
         end else if (mux_mode) begin
            a.active  = strobe_or_read_n;
            a.is_read = rw_or_write_n;
         end else begin
            a.active  = !strobe_or_read_n;
            a.is_read = rw_or_write_n;
         end
      end
      return a;
   endfunction

endpackage
`default_nettype wire

// ==== tb/tdm_switch_cpu_port_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
module tdm_switch_cpu_port_asserts (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic rd_wr_style,
   input wire logic bus_mux_select,
   input wire logic device_reset_n,
   input wire logic cs_n,
   input wire logic strobe_or_read_n,
   input wire logic rw_or_write_n,
   input wire logic addr_latch_strobe,
   input wire logic low_host_oe,
   input wire logic low_dev_oe,
   input wire logic upper_dev_oe,
   input wire logic ack_dev_out,
   input wire logic ack_dev_oe,
   input wire logic transfer_ack_n
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   AST_RESET_FLOAT: assert property (
      !device_reset_n |-> !low_dev_oe && !upper_dev_oe && !ack_dev_oe)
      else $error("device drives bus while held in reset");
   AST_RESET_HOLD: assert property (
      $fell(device_reset_n) |-> !device_reset_n [*3])
      else $error("device reset pulse too short");
   AST_CS_GATE: assert property (
      $fell(transfer_ack_n) |-> !$past(cs_n))
      else $error("ack without chip select");
   AST_NONMUX_ACK: assert property (
      !bus_mux_select && !cs_n && $fell(strobe_or_read_n)
      |-> ##[1:3] !transfer_ack_n)
      else $error("no ack after low data strobe");
   AST_MUX_DS_ACK: assert property (
      bus_mux_select && !rd_wr_style && !cs_n && $rose(strobe_or_read_n)
      |-> ##[1:3] !transfer_ack_n)
      else $error("no ack after high data strobe");
   AST_RDWR_READ: assert property (
      bus_mux_select && rd_wr_style && !cs_n && !strobe_or_read_n
      && !transfer_ack_n |-> low_dev_oe && upper_dev_oe)
      else $error("read strobe without device drive");
   AST_RDWR_WRITE: assert property (
      bus_mux_select && rd_wr_style && !rw_or_write_n
      |-> !low_dev_oe && !upper_dev_oe)
      else $error("device drives during write strobe");
   AST_DS_DIR: assert property (
      !(bus_mux_select && rd_wr_style) && !cs_n && !transfer_ack_n
      && (bus_mux_select ? strobe_or_read_n : !strobe_or_read_n)
      |-> low_dev_oe == rw_or_write_n && upper_dev_oe == rw_or_write_n)
      else $error("data direction does not follow rw");
   AST_ALE_ADDR: assert property (
      bus_mux_select && addr_latch_strobe |-> low_host_oe && !low_dev_oe)
      else $error("address phase not driven by host");
   AST_NONMUX_ALE: assert property (
      !bus_mux_select |-> !addr_latch_strobe)
      else $error("latch strobe used in nonmux mode");
   AST_ACK_RELEASE: assert property (
      ack_dev_oe && $rose(ack_dev_out) |=> !ack_dev_oe)
      else $error("ack not released after high drive");
   AST_CS_DRIVE: assert property (
      low_dev_oe || upper_dev_oe |-> !cs_n)
      else $error("device drives data without chip select");
endmodule
`default_nettype wire

// ==== tb/test_tdm_switch_cpu_port.sv ====
`timescale 1ns/10ps
`default_nettype none
module test_tdm_switch_cpu_port;
   logic        clk_sys, rst_n, mux_mode, rd_wr_style, wide_frame_cfg;
   logic        reset_req, req_valid, req_write, req_ready, resp_valid;
   logic        wide_frame_mode, auto_polarity_mode;
   logic        serial_out_hiz, mem_wr_pulse;
   logic [7:0]  req_addr, mem_wr_addr, wa;
   logic [15:0] req_wdata, resp_rdata, mem_wr_data, wd, cnt;
   int          fails, n_checks;
   wire logic   dev_rst_n;

   cpu_port_if cpu_port_if_i ();
   // host's reset pin gates the device on top of the system reset
   assign dev_rst_n = rst_n & cpu_port_if_i.device_reset_n;

   cpu_port_host cpu_port_host_i (.clk_sys(clk_sys), .rst_n(rst_n),
      .bus(cpu_port_if_i), .mux_mode(mux_mode), .rd_wr_style(rd_wr_style),
      .wide_frame_cfg(wide_frame_cfg), .reset_req(reset_req),
      .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
      .req_wdata(req_wdata), .req_ready(req_ready),
      .resp_valid(resp_valid), .resp_rdata(resp_rdata));
   cpu_port_device cpu_port_device_i (.clk_sys(clk_sys), .rst_n(dev_rst_n),
      .bus(cpu_port_if_i), .rd_wr_style(rd_wr_style),
      .wide_frame_mode(wide_frame_mode),
      .auto_polarity_mode(auto_polarity_mode),
      .serial_out_hiz(serial_out_hiz), .mem_wr_pulse(mem_wr_pulse),
      .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data));
   tdm_switch_cpu_port_asserts tdm_switch_cpu_port_asserts_i (
      .clk_sys(clk_sys), .rst_n(rst_n), .rd_wr_style(rd_wr_style),
      .bus_mux_select(cpu_port_if_i.bus_mux_select),
      .device_reset_n(cpu_port_if_i.device_reset_n),
      .cs_n(cpu_port_if_i.cs_n),
      .strobe_or_read_n(cpu_port_if_i.strobe_or_read_n),
      .rw_or_write_n(cpu_port_if_i.rw_or_write_n),
      .addr_latch_strobe(cpu_port_if_i.addr_latch_strobe),
      .low_host_oe(cpu_port_if_i.low_host_oe),
      .low_dev_oe(cpu_port_if_i.low_dev_oe),
      .upper_dev_oe(cpu_port_if_i.upper_dev_oe),
      .ack_dev_out(cpu_port_if_i.ack_dev_out),
      .ack_dev_oe(cpu_port_if_i.ack_dev_oe),
      .transfer_ack_n(cpu_port_if_i.transfer_ack_n));

   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   // the write pulse lasts one cycle, so latch it for later comparison
   always @(posedge clk_sys) begin
      if (mem_wr_pulse === 1'b1) begin
         wa <= mem_wr_addr;
         wd <= mem_wr_data;
      end
   end

   task automatic chk16(input string nm, input logic [15:0] e,
                        input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk1(input string nm, input logic e, input logic g);
      chk16(nm, {15'h0000, e}, {15'h0000, g});
   endtask

   task automatic xfer(input logic wr, input logic [7:0] a,
                       input logic [15:0] d);
      int n;
      n = 0;
      while (req_ready !== 1'b1 && n < 40) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      req_valid = 1'b1;
      req_write = wr;
      req_addr = a;
      req_wdata = d;
      @(posedge clk_sys);
      #1;
      req_valid = 1'b0;
      n = 0;
      while (resp_valid !== 1'b1 && n < 40) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      chk1("resp_valid", 1'b1, resp_valid);
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      xfer(1'b1, a, d);
      chk16("wr_addr", {8'h00, a}, {8'h00, wa});
      chk16("wr_data", d, wd);
   endtask

   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      xfer(1'b0, a, 16'h0000);
      chk16("rdata", e, resp_rdata);
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   initial begin
      #400000;
      fails++;
      summarize();
   end

   initial begin
      {rst_n, mux_mode, rd_wr_style, wide_frame_cfg, reset_req} = 5'h00;
      {req_valid, req_write, req_addr, req_wdata} = 26'h0000000;
      fails = 0;
      n_checks = 0;
      repeat (20) @(posedge clk_sys);
      #1;
      rst_n = 1'b1;
      // nonmux, mux data strobe, mux read/write strobes
      for (int m = 0; m < 3; m++) begin
         mux_mode = (m != 0);
         rd_wr_style = (m == 2);
         wide_frame_cfg = m[0];
         repeat (2) @(posedge clk_sys);
         #1;
         chk1("wide", m[0], wide_frame_mode);
         chk1("auto_pol", !m[0], auto_polarity_mode);
         wr(8'hff, 16'ha5c3 ^ 16'(m));
         wr(8'h00, 16'h5a3c ^ 16'(m));
         rd(8'hff, 16'ha5c3 ^ 16'(m));
         rd(8'h00, 16'h5a3c ^ 16'(m));
         $display("test mode %0d done", m);
      end
      wr(8'h42, 16'h1234);
      wide_frame_cfg = 1'b1;
      reset_req = 1'b1;
      cnt = 16'h0000;
      while (cpu_port_if_i.device_reset_n !== 1'b0 && cnt < 20) begin
         @(posedge clk_sys);
         #1;
         cnt++;
      end
      reset_req = 1'b0;
      chk1("hiz", 1'b1, serial_out_hiz);
      chk1("wide_rst", 1'b0, wide_frame_mode);
      chk1("low_oe", 1'b0, cpu_port_if_i.low_dev_oe);
      chk1("ack_n", 1'b1, cpu_port_if_i.transfer_ack_n);
      cnt = 16'h0000;
      while (cpu_port_if_i.device_reset_n === 1'b0 && cnt < 20) begin
         @(posedge clk_sys);
         #1;
         cnt++;
      end
      chk16("rst_len", 16'h0003, cnt);
      @(posedge clk_sys);
      #1;
      chk1("wide_after", 1'b1, wide_frame_mode);
      chk1("hiz_after", 1'b0, serial_out_hiz);
      rd(8'h42, 16'h1234);
      $display("test device reset done");
      summarize();
   end
endmodule
`default_nettype wire
